// ==== verilog/tcc_core.v ====
`timescale 1ns/1ps
`include "tcc_regs.vh"

// Overview of operation
// [RULE1] count advances on routed events or on divided counting clock pulses
// [RULE2] width selectable 8, 16 or 32 bits; width sets the top value
// [RULE3] counts up or down; default up, wrapping to zero after top
// [RULE4] compare channel toggles its waveform output when count equals its value
// [RULE5] capture channel latches the count when its input event arrives
// [RULE6] keeps counting while its clock runs; requests and events work asleep
// [RULE7] even/odd pair share one counting clock; no per-instance clock choice
// [RULE8] bus-side configuration is synchronised into the counting domain
// [RULE9] counting suspends during debug halt unless told to keep running
// [RULE10] configuration writes lockable by access guard; values never locked
// [RULE11] locking lifted during debug halt and for external debugger writes
// [RULE12] requests and events on wrap and on compare match or capture
// [RULE13] divider ratios from one up to one pulse per 1024
// [RULE14] counter width defaults to 16 bits after reset
// [RULE15] two waveform outputs, one per channel, showing match toggles
module tcc_core
(
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        cfg_wr_tgl_i,
  input  wire        cfg_enable_i,
  input  wire [1:0]  cfg_width_i,
  input  wire        cfg_down_i,
  input  wire [2:0]  cfg_div_i,
  input  wire        cfg_evcount_i,
  input  wire [1:0]  cfg_capture_i,
  input  wire        cfg_dbg_run_i,
  input  wire [31:0] cc0_val_i,
  input  wire [31:0] cc1_val_i,
  input  wire        guard_lock_i,
  input  wire        ext_dbg_wr_i,
  input  wire        dbg_halt_i,
  input  wire        count_event_i,
  input  wire [1:0]  capture_event_i,
  output reg  [31:0] count_o,
  output reg  [31:0] capture0_o,
  output reg  [31:0] capture1_o,
  output reg  [1:0]  waveform_out_o,
  output reg         irq_wrap_o,
  output reg  [1:0]  irq_match_o,
  output reg         event_wrap_o,
  output reg  [1:0]  event_match_o,
  output reg         wr_refused_o
);

  // async inputs: stage one, stage two, and a third stage for edges
  reg        wr_s1_r;
  reg        wr_s2_r;
  reg        wr_s3_r;
  reg        halt_s1_r;
  reg        halt_s2_r;
  reg [2:0]  ev_s1_r;
  reg [2:0]  ev_s2_r;
  reg [2:0]  ev_s3_r;

  // configuration held in the counting domain
  reg        enable_r;
  reg [1:0]  width_r;
  reg        down_r;
  reg [2:0]  div_r;
  reg        evcount_r;
  reg [1:0]  capture_r;
  reg        dbg_run_r;
  reg [31:0] cc0_r;
  reg [31:0] cc1_r;

  wire        wr_pulse;
  wire [2:0]  ev_pulse;
  wire        unlocked;
  wire        run;
  wire        tick;
  wire        step;
  wire [31:0] top;
  wire        at_end;
  reg  [31:0] count_nxt;
  reg  [1:0]  hit;

  // top value for a width code
  function [31:0] tcc_top;
    input [1:0] w;
    begin
      case (w)
        `TCC_WIDTH_8:  tcc_top = `TCC_TOP_8;
        `TCC_WIDTH_32: tcc_top = `TCC_TOP_32;
        default:       tcc_top = `TCC_TOP_16;
      endcase
    end
  endfunction

  // two-flop synchronisers; edges look only at stages two and three
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_s1_r   <= 1'b0;
      wr_s2_r   <= 1'b0;
      wr_s3_r   <= 1'b0;
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
      ev_s1_r   <= 3'h0;
      ev_s2_r   <= 3'h0;
      ev_s3_r   <= 3'h0;
    end
    else
    begin
      wr_s1_r   <= cfg_wr_tgl_i;                     // [RULE8]
      wr_s2_r   <= wr_s1_r;
      wr_s3_r   <= wr_s2_r;
      halt_s1_r <= dbg_halt_i;
      halt_s2_r <= halt_s1_r;
      ev_s1_r   <= {capture_event_i, count_event_i};
      ev_s2_r   <= ev_s1_r;
      ev_s3_r   <= ev_s2_r;
    end
  end

  assign wr_pulse = wr_s2_r ^ wr_s3_r;             // bus write toggle arrived [RULE8]
  assign ev_pulse = ev_s2_r & ~ev_s3_r;            // rising edge of each event line
  assign unlocked = !guard_lock_i || ext_dbg_wr_i || halt_s2_r;  // [RULE10] [RULE11]

  // config data is sampled only on the synchronised toggle, so the bus side
  // must hold it steady from its toggle until three counting clocks later
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      enable_r     <= 1'b0;
      width_r      <= `TCC_WIDTH_RST;                // [RULE14]
      down_r       <= 1'b0;                          // [RULE3]
      div_r        <= `TCC_DIV_RST;
      evcount_r    <= 1'b0;
      capture_r    <= 2'h0;
      dbg_run_r    <= 1'b0;
      cc0_r        <= 32'h00000000;
      cc1_r        <= 32'h00000000;
      wr_refused_o <= 1'b0;
    end
    else if (wr_pulse)
    begin
      cc0_r        <= cc0_val_i;                     // compare values never locked [RULE10]
      cc1_r        <= cc1_val_i;
      wr_refused_o <= !unlocked;
      if (unlocked)
      begin
        enable_r  <= cfg_enable_i;
        width_r   <= cfg_width_i;                    // [RULE2]
        down_r    <= cfg_down_i;
        div_r     <= cfg_div_i;
        evcount_r <= cfg_evcount_i;
        capture_r <= cfg_capture_i;
        dbg_run_r <= cfg_dbg_run_i;
      end
    end
  end

  // halted for debug unless told to keep running [RULE9]
  assign run = enable_r && (!halt_s2_r || dbg_run_r);

  tcc_prescaler u_prescaler
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (run),
    .sel_i    (div_r),
    .tick_o   (tick)
  );

  // events bypass the divider [RULE1]
  assign step   = run && (evcount_r ? ev_pulse[0] : tick);
  assign top    = tcc_top(width_r);                // [RULE2]
  assign at_end = down_r ? (count_o == 32'h00000000) : (count_o == top);

  // next count and compare hits against the value being entered
  always @*
  begin
    count_nxt = count_o;
    hit       = 2'h0;
    if (step)
    begin
      if (at_end)
        count_nxt = down_r ? top : 32'h00000000;     // [RULE3]
      else if (down_r)
        count_nxt = count_o - 32'h00000001;
      else
        count_nxt = count_o + 32'h00000001;
      hit[0] = !capture_r[0] && (count_nxt == (cc0_r & top));  // [RULE4]
      hit[1] = !capture_r[1] && (count_nxt == (cc1_r & top));  // [RULE4]
    end
  end

  // counter, waveforms, captures and outgoing pulses; these keep working in
  // any low-power state as long as the counting clock runs [RULE6] [RULE7]
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_o        <= 32'h00000000;
      capture0_o     <= 32'h00000000;
      capture1_o     <= 32'h00000000;
      waveform_out_o <= 2'h0;
      irq_wrap_o     <= 1'b0;
      irq_match_o    <= 2'h0;
      event_wrap_o   <= 1'b0;
      event_match_o  <= 2'h0;
    end
    else
    begin
      // a width change may leave the count above the new top; mask it to the new width
      count_o        <= count_nxt & top;
      waveform_out_o <= waveform_out_o ^ hit;        // [RULE15]
      irq_wrap_o     <= step && at_end;              // [RULE12]
      event_wrap_o   <= step && at_end;              // [RULE12]
      irq_match_o    <= hit;
      event_match_o  <= hit;
      if (run && capture_r[0] && ev_pulse[1])
      begin
        capture0_o     <= count_o;                   // [RULE5]
        irq_match_o[0] <= 1'b1;                      // [RULE12]
        event_match_o[0] <= 1'b1;
      end
      if (run && capture_r[1] && ev_pulse[2])
      begin
        capture1_o     <= count_o;                   // [RULE5]
        irq_match_o[1] <= 1'b1;
        event_match_o[1] <= 1'b1;
      end
    end
  end

endmodule

// ==== verilog/tcc_regs.vh ====
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// counter width selection codes
`define TCC_WIDTH_16      2'h0
`define TCC_WIDTH_8       2'h1
`define TCC_WIDTH_32      2'h2
`define TCC_WIDTH_RST     2'h0

// top values per width
`define TCC_TOP_8         32'h000000FF
`define TCC_TOP_16        32'h0000FFFF
`define TCC_TOP_32        32'hFFFFFFFF

// divider selection codes: 1,2,4,8,16,64,256,1024
`define TCC_DIV_1         3'h0
`define TCC_DIV_2         3'h1
`define TCC_DIV_4         3'h2
`define TCC_DIV_8         3'h3
`define TCC_DIV_16        3'h4
`define TCC_DIV_64        3'h5
`define TCC_DIV_256       3'h6
`define TCC_DIV_1024      3'h7
`define TCC_DIV_RST       3'h0

// divider terminal counts (ratio minus one)
`define TCC_TC_1          10'h000
`define TCC_TC_2          10'h001
`define TCC_TC_4          10'h003
`define TCC_TC_8          10'h007
`define TCC_TC_16         10'h00F
`define TCC_TC_64         10'h03F
`define TCC_TC_256        10'h0FF
`define TCC_TC_1024       10'h3FF

`endif

// ==== verilog/tcc_prescaler.v ====
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_prescaler
(
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       run_i,
  input  wire [2:0] sel_i,
  output reg        tick_o
);

  reg  [9:0] div_cnt_r;
  wire [9:0] term_cnt;

  // map a selection code to its terminal count
  function [9:0] tcc_term;
    input [2:0] sel;
    begin
      case (sel)
        `TCC_DIV_1:    tcc_term = `TCC_TC_1;
        `TCC_DIV_2:    tcc_term = `TCC_TC_2;
        `TCC_DIV_4:    tcc_term = `TCC_TC_4;
        `TCC_DIV_8:    tcc_term = `TCC_TC_8;
        `TCC_DIV_16:   tcc_term = `TCC_TC_16;
        `TCC_DIV_64:   tcc_term = `TCC_TC_64;
        `TCC_DIV_256:  tcc_term = `TCC_TC_256;
        default:       tcc_term = `TCC_TC_1024;
      endcase
    end
  endfunction

  assign term_cnt = tcc_term(sel_i);

  // divider: one tick per selected number of clock cycles while running;
  // the >= compare keeps a ratio change from leaving the count stranded
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_cnt_r <= 10'h000;
      tick_o    <= 1'b0;
    end
    else if (!run_i)
    begin
      tick_o <= 1'b0;                               // tick cleared, divider count held while halted [RULE9]
    end
    else if (div_cnt_r >= term_cnt)
    begin
      div_cnt_r <= 10'h000;
      tick_o    <= 1'b1;                            // [RULE13]
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 10'h001;
      tick_o    <= 1'b0;
    end
  end

endmodule

// ==== bench/tcc_core_monitor.sv ====
`timescale 1ns/1ps
module tcc_core_monitor
(
  input wire        clk_i,
  input wire        arst_n_i,
  input wire        cfg_wr_tgl_i,
  input wire        cfg_dbg_run_i,
  input wire        dbg_halt_i,
  input wire [31:0] count_o,
  input wire [31:0] capture0_o,
  input wire [1:0]  waveform_out_o,
  input wire        irq_wrap_o,
  input wire        event_wrap_o,
  input wire [1:0]  irq_match_o,
  input wire [1:0]  event_match_o,
  input wire        wr_refused_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // count and waveforms held clear while reset is low
  AST_RST_CLR: assert property (disable iff (1'b0) !arst_n_i |-> count_o == 32'h0 && waveform_out_o == 2'h0)
    else $error("outputs not clear in reset");
  // requests and events must leave together
  AST_WRAP_EV: assert property (irq_wrap_o == event_wrap_o)
    else $error("wrap request and event differ");
  AST_MATCH_EV: assert property (irq_match_o == event_match_o)
    else $error("match request and event differ");
  AST_WRAP_PULSE: assert property (irq_wrap_o |=> !irq_wrap_o)
    else $error("wrap pulse too long");
  // halt needs two sync flops, so allow a settling margin
  AST_HALT_HOLD: assert property ((dbg_halt_i && !cfg_dbg_run_i) [*4] |=> $stable(count_o))
    else $error("count moved in debug halt");
  // toggles are at least four clocks apart, so parity shows a write
  AST_REFUSE_SRC: assert property ($changed(wr_refused_o) |-> $past(cfg_wr_tgl_i) != $past(cfg_wr_tgl_i, 4))
    else $error("refusal flag moved without a write");
  AST_WAVE0: assert property ($changed(waveform_out_o[0]) |-> irq_match_o[0] || $past(irq_match_o[0]))
    else $error("waveform 0 toggled without match");
  AST_WAVE1: assert property ($changed(waveform_out_o[1]) |-> irq_match_o[1] || $past(irq_match_o[1]))
    else $error("waveform 1 toggled without match");
  AST_CAPT0: assert property ($changed(capture0_o) |-> irq_match_o[0] || $past(irq_match_o[0]))
    else $error("capture 0 moved without its pulse");
endmodule

bind tcc_core tcc_core_monitor u_tcc_core_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cfg_wr_tgl_i(cfg_wr_tgl_i), .cfg_dbg_run_i(cfg_dbg_run_i), .dbg_halt_i(dbg_halt_i),
  .count_o(count_o), .capture0_o(capture0_o), .waveform_out_o(waveform_out_o),
  .irq_wrap_o(irq_wrap_o), .event_wrap_o(event_wrap_o), .irq_match_o(irq_match_o),
  .event_match_o(event_match_o), .wr_refused_o(wr_refused_o));

// ==== bench/tcc_evnet.sv ====
`timescale 1ns/1ps
// event routing stand-in: each request becomes a three-cycle strobe
module tcc_evnet
(
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire [2:0] fire_i,
  output reg  [2:0] line_o
);
  reg [2:0] a_r, b_r;
  // stretched so the two-flop sync cannot miss an edge
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) {line_o, a_r, b_r} <= 9'h0;
    else {line_o, b_r, a_r} <= {fire_i | a_r | b_r, a_r, fire_i};
endmodule

// ==== bench/timer_counter_core_tb.sv ====
`timescale 1ns/1ps
module timer_counter_core_tb;
  // reset starts high so that the time-zero assertion is a real falling edge
  reg        clk_i = 1'b0, arst_n_i = 1'b1, tgl = 1'b0, en = 1'b0, down = 1'b0, evc = 1'b0;
  reg        run = 1'b0, lock = 1'b0, ext = 1'b0, halt = 1'b0;
  reg [1:0]  wid = 2'h0, cap = 2'h0;
  reg [2:0]  div = 3'h0, fire = 3'h0;
  reg [31:0] cc0 = 32'h0, cc1 = 32'h0, c1;
  wire [31:0] cnt, cp0, cp1;
  wire [1:0]  wo, im, em;
  wire [2:0]  ln;
  wire        iw, ew, rfs;
  integer     fail_count = 0, checks_done = 0, i, k;
  always #5 clk_i = ~clk_i;
  tcc_core u_tcc_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_wr_tgl_i(tgl), .cfg_enable_i(en),
    .cfg_width_i(wid), .cfg_down_i(down), .cfg_div_i(div), .cfg_evcount_i(evc),
    .cfg_capture_i(cap), .cfg_dbg_run_i(run), .cc0_val_i(cc0), .cc1_val_i(cc1),
    .guard_lock_i(lock), .ext_dbg_wr_i(ext), .dbg_halt_i(halt), .count_event_i(ln[0]),
    .capture_event_i(ln[2:1]), .count_o(cnt), .capture0_o(cp0), .capture1_o(cp1),
    .waveform_out_o(wo), .irq_wrap_o(iw), .irq_match_o(im), .event_wrap_o(ew),
    .event_match_o(em), .wr_refused_o(rfs));
  tcc_evnet u_tcc_evnet (.clk_i(clk_i), .arst_n_i(arst_n_i), .fire_i(fire), .line_o(ln));
  // wait n edges, then settle past the edge for sampling
  task tk(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (e !== g)
      begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one config write; data is changed at the same edge as the toggle and held to
  // the next write, so the synchronised toggle always samples settled data
  task wr;
    begin
      tgl <= ~tgl;
      tk(5);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // bounded wait for a wrap pulse
  task wwrap;
    begin
      i = 0;
      while (iw !== 1'b1 && i < 600)
      begin
        tk(1);
        i = i + 1;
      end
      if (iw !== 1'b1)
      begin
        chk("wrapwait", 1, 0);
        conclude;
      end
    end
  endtask
  initial
  begin
    #900000;
    chk("timeout", 1, 0);
    conclude;
  end
  // reset over two edges; counter bits 31:2 and waveforms must come out clear
  task t_reset;
    begin
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      tk(1);
      chk("rstcnt", 32'h0, {cnt[31:2], wo});
      $display("test reset done");
    end
  endtask
  // 8-bit up count; both compare channels toggle once before the first wrap
  task t_up8;
    begin
      @(posedge clk_i);
      en  <= 1'b1;
      wid <= 2'h1;
      cc0 <= 32'h00000010;
      cc1 <= 32'h00000020;
      wr;
      wwrap;
      chk("wrap8", 32'h1, cnt < 32'h4);
      chk("wave", 32'h3, wo);
      $display("test up8 done");
    end
  endtask
  // 16-bit down count wraps from zero to the 16-bit top
  task t_down16;
    begin
      tk(100);
      @(posedge clk_i);
      wid  <= 2'h0;
      down <= 1'b1;
      wr;
      wwrap;
      chk("wrap16", 32'h1, cnt > 32'hFF00 && cnt <= 32'hFFFF);
      $display("test down16 done");
    end
  endtask
  // 32-bit up count through the divider at /4 and /1024
  task t_divider;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        @(posedge clk_i);
        wid  <= 2'h2;
        down <= 1'b0;
        div  <= k ? 3'h7 : 3'h2;
        wr;
        c1 = cnt;
        tk(k ? 4096 : 40);
        chk("div", 32'hA - 32'h6 * k, cnt - c1);
      end
      $display("test divider done");
    end
  endtask
  // debug halt freezes the count unless debug-run is set
  task t_debug;
    begin
      @(posedge clk_i);
      div <= 3'h0;
      run <= 1'b0;
      wr;
      @(posedge clk_i);
      halt <= 1'b1;
      tk(4);
      c1 = cnt;
      tk(20);
      chk("halt", c1, cnt);
      @(posedge clk_i);
      run <= 1'b1;
      wr;
      c1 = cnt;
      tk(20);
      chk("dbgrun", c1 + 32'h14, cnt);
      @(posedge clk_i);
      halt <= 1'b0;
      run  <= 1'b0;
      tk(4);
      $display("test debug done");
    end
  endtask
  // guard refuses config writes; debugger writes and debug halt bypass it
  task t_lock;
    begin
      @(posedge clk_i);
      lock <= 1'b1;
      en   <= 1'b0;
      wr;
      chk("lockref", 32'h1, rfs);
      c1 = cnt;
      tk(10);
      chk("lockrun", c1 + 32'hA, cnt);
      @(posedge clk_i);
      ext <= 1'b1;
      wr;
      chk("extwr", 32'h0, rfs);
      c1 = cnt;
      tk(10);
      chk("stopped", c1, cnt);
      @(posedge clk_i);
      ext  <= 1'b0;
      halt <= 1'b1;
      tk(4);
      @(posedge clk_i);
      en <= 1'b1;
      wr;
      chk("haltunl", 32'h0, rfs);
      $display("test lock done");
    end
  endtask
  // count on routed event strobes only, never on divider ticks
  task t_events;
    begin
      @(posedge clk_i);
      halt <= 1'b0;
      lock <= 1'b0;
      evc  <= 1'b1;
      wr;
      c1 = cnt;
      tk(10);
      chk("noevent", c1, cnt);
      for (k = 0; k < 5; k = k + 1)
      begin
        @(posedge clk_i);
        fire <= 3'h1;
        @(posedge clk_i);
        fire <= 3'h0;
        tk(6);
      end
      chk("events", c1 + 32'h5, cnt);
      $display("test events done");
    end
  endtask
  // both channels latch the count before the step of the capture cycle,
  // which is four steps behind the count seen three clocks later
  task t_capture;
    begin
      @(posedge clk_i);
      evc <= 1'b0;
      cap <= 2'h3;
      wr;
      @(posedge clk_i);
      fire <= 3'h6;
      @(posedge clk_i);
      fire <= 3'h0;
      tk(3);
      chk("capirq", 32'h3, im);
      tk(3);
      chk("capt0", cnt - 32'h4, cp0);
      chk("capt1", cnt - 32'h4, cp1);
      $display("test capture done");
    end
  endtask
  initial
  begin
    t_reset;
    t_up8;
    t_down16;
    t_divider;
    t_debug;
    t_lock;
    t_events;
    t_capture;
    conclude;
  end
endmodule
